// ===== rtl/vsf_sink.sv
/*
 * Pixel sink end: checks frame and line markers, drops the rest of a broken frame, and buffers
 * accepted pixels in a two-entry buffer toward the user side.
 * Assumes the source shares ref_clk and aclken.
 */
`timescale 1ns/1ps
`include "vsf_regs.svh"

module vsf_sink #(
	parameter int COMP_MAX = `VSF_MAX_COMPONENTS,
	parameter int DATA_WIDTH = 48
) (
	// Link
	vsf_link_if.sink link,
	// Format
	input wire logic [2:0] cfg_ncomp,
	input wire logic [1:0] cfg_cwidth,
	input wire logic [`VSF_CNT_WIDTH-1:0] cfg_line_width,
	input wire logic [`VSF_CNT_WIDTH-1:0] cfg_line_count,
	// User pixels
	output logic pix_valid,
	output logic [COMP_MAX*16-1:0] pix_comp,
	output logic pix_sof,
	output logic pix_eol,
	input wire logic pix_ready,
	// Status
	output logic frame_error,
	output logic locked
);
	import vsf_pkg::*;

	localparam int BW = COMP_MAX * 16 + 2;

	// =============================================================
	// Framing check
	// =============================================================
	vsf_sink_state_e state;
	vsf_sink_state_e next_state;
	vsf_count_t x_pos;
	vsf_count_t y_pos;
	vsf_count_t next_x_pos;
	vsf_count_t next_y_pos;
	logic next_frame_error;
	logic next_locked;
	logic beat;
	logic sof;
	logic x_end;
	logic y_end;
	logic keep;
	logic [COMP_MAX*16-1:0] unpacked;
	logic buf_in_ready;
	logic relock;
	logic first_end;

	// Transfer only on valid with ready; ready falls when the buffer is full.
	assign beat = link.tvalid && link.tready && link.aclken;
	assign sof = link.tuser[`VSF_SOF_BIT];
	assign x_end = (x_pos == cfg_line_width - 1'b1);
	assign y_end = (y_pos == cfg_line_count - 1'b1);
	// A frame's first pixel ends its line only when lines are one pixel long.
	assign first_end = (cfg_line_width == vsf_count_t'(1));

	// Unpack in the same fixed order the source used.
	always_comb begin
		logic [4:0] bits;
		bits = vsf_comp_bits(cfg_cwidth);
		unpacked = '0;
		for (int c = 0; c < COMP_MAX; c++) begin
			for (int b = 0; b < 16; b++) begin
				if (c < int'(cfg_ncomp) && b < int'(bits) && c * int'(bits) + b < DATA_WIDTH) begin
					unpacked[c * 16 + b] = link.tdata[c * int'(bits) + b];
				end
			end
		end
	end

	always_comb begin
		next_state = state;
		next_x_pos = x_pos;
		next_y_pos = y_pos;
		next_frame_error = 1'b0;
		keep = 1'b0;
		relock = 1'b0;
		if (beat) begin
			case (state)
				VSF_HUNT, VSF_DROP: begin
					// Wait for a frame start to relock.
					relock = sof;
				end
				VSF_ACTIVE: begin
					// A misplaced marker ruins the frame.
					// An early frame start also begins the next frame at once.
					if (sof) begin
						next_frame_error = 1'b1;
						relock = 1'b1;
					end else if (link.tlast != x_end) begin
						next_frame_error = 1'b1;
						next_state = VSF_DROP;
					end else begin
						keep = 1'b1;
						if (x_end) begin
							next_x_pos = '0;
							if (y_end) begin
								next_y_pos = '0;
								next_state = VSF_HUNT;
							end else begin
								next_y_pos = y_pos + 1'b1;
							end
						end else begin
							next_x_pos = x_pos + 1'b1;
						end
					end
				end
				default: next_state = VSF_HUNT;
			endcase
			if (relock) begin
				next_state = VSF_DROP;
				next_y_pos = '0;
				if (link.tlast == first_end) begin
					keep = 1'b1;
					next_state = VSF_ACTIVE;
					next_x_pos = first_end ? '0 : vsf_count_t'(1);
					if (first_end) begin
						next_y_pos = vsf_count_t'(1);
						if (cfg_line_count == vsf_count_t'(1)) begin
							next_y_pos = '0;
							next_state = VSF_HUNT;
						end
					end
				end
			end
		end
		next_locked = (next_state == VSF_ACTIVE);
	end

	always_ff @(posedge link.ref_clk or posedge link.rst) begin
		if (link.rst) begin
			state <= VSF_HUNT;
			x_pos <= '0;
			y_pos <= '0;
			frame_error <= 1'b0;
			locked <= 1'b0;
		end else begin
			state <= next_state;
			x_pos <= next_x_pos;
			y_pos <= next_y_pos;
			frame_error <= next_frame_error;
			locked <= next_locked;
		end
	end

	// =============================================================
	// Two-entry buffer
	// =============================================================
	// Dropped beats are still accepted so a broken frame drains instead of stalling.
	// Pixels of a frame that breaks midway have already left; the error pulse flags it.
	logic [BW-1:0] mem [`VSF_BUF_DEPTH];
	logic [BW-1:0] next_mem [`VSF_BUF_DEPTH];
	logic [1:0] count;
	logic [1:0] next_count;
	logic push;
	logic pop;

	assign buf_in_ready = (next_count != 2'(`VSF_BUF_DEPTH));
	assign push = beat && keep;
	assign pop = pix_valid && pix_ready;

	always_comb begin
		next_mem = mem;
		next_count = count;
		if (pop) begin
			next_mem[0] = mem[1];
		end
		if (push) begin
			// Markers are stored with their own pixel.
			next_mem[(pop ? count - 2'h1 : count) == 2'h0 ? 0 : 1] = {sof, link.tlast, unpacked};
		end
		next_count = count + 2'(push) - 2'(pop);
	end

	always_ff @(posedge link.ref_clk or posedge link.rst) begin
		if (link.rst) begin
			mem[0] <= '0;
			mem[1] <= '0;
			count <= 2'h0;
		end else begin
			mem <= next_mem;
			count <= next_count;
		end
	end

	// Ready follows the next fill level, so a full buffer stalls the link.
	always_ff @(posedge link.ref_clk or posedge link.rst) begin
		if (link.rst) begin
			link.tready <= 1'b0;
			pix_valid <= 1'b0;
			pix_comp <= '0;
			pix_sof <= 1'b0;
			pix_eol <= 1'b0;
		end else begin
			link.tready <= buf_in_ready;
			pix_valid <= (next_count != 2'h0);
			pix_comp <= next_mem[0][COMP_MAX*16-1:0];
			pix_eol <= next_mem[0][COMP_MAX*16];
			pix_sof <= next_mem[0][COMP_MAX*16+1];
		end
	end

endmodule : vsf_sink

// ===== rtl/vsf_regs.svh
/*
 * Timing counts, limits and format constants for the video stream framing link.
 * Assumes inclusion by its bare name from the package, the link interface and the two end modules.
 */
`ifndef VSF_REGS_SVH
`define VSF_REGS_SVH

// =============================================================
// Format limits
// =============================================================
`define VSF_MAX_COMPONENTS 4
`define VSF_MAX_LINE_WIDTH 8192
`define VSF_DEF_LINE_WIDTH 1920
`define VSF_DEF_LINE_COUNT 1080
`define VSF_CNT_WIDTH 14

// =============================================================
// Component widths and their encodings
// =============================================================
`define VSF_CW_8 2'h0
`define VSF_CW_10 2'h1
`define VSF_CW_12 2'h2
`define VSF_CW_16 2'h3

// =============================================================
// User sideband layout
// =============================================================
`define VSF_SOF_BIT 0
`define VSF_USER_WIDTH 1

// =============================================================
// Buffer shape
// =============================================================
`define VSF_BUF_DEPTH 2

`endif

// ===== rtl/vsf_pkg.sv
/*
 * Types shared by both ends of the video stream framing link.
 * Assumes vsf_regs.svh sits on the include path.
 */
`include "vsf_regs.svh"

package vsf_pkg;

	// =============================================================
	// Types
	// =============================================================
	typedef logic [`VSF_CNT_WIDTH-1:0] vsf_count_t;
	typedef logic [1:0] vsf_cwidth_t;
	typedef logic [2:0] vsf_ncomp_t;

	typedef enum logic [1:0] {
		VSF_HUNT,
		VSF_ACTIVE,
		VSF_DROP
	} vsf_sink_state_e;

	// Bits per component for a given width code.
	function automatic logic [4:0] vsf_comp_bits(input vsf_cwidth_t code);
		case (code)
			`VSF_CW_8: vsf_comp_bits = 5'h08;
			`VSF_CW_10: vsf_comp_bits = 5'h0a;
			`VSF_CW_12: vsf_comp_bits = 5'h0c;
			default: vsf_comp_bits = 5'h10;
		endcase
	endfunction : vsf_comp_bits

endpackage : vsf_pkg

// ===== rtl/vsf_link_if.sv
/*
 * Stream link between the pixel source and the pixel sink.
 * Assumes both ends share ref_clk and rst.
 */
`timescale 1ns/1ps
`include "vsf_regs.svh"

interface vsf_link_if #(
	parameter int DATA_WIDTH = 48
) (
	input wire logic ref_clk,
	input wire logic rst
);
	logic tvalid;
	logic tready;
	logic [DATA_WIDTH-1:0] tdata;
	logic tlast;
	logic [`VSF_USER_WIDTH-1:0] tuser;
	logic aclken;

	modport source (
		input ref_clk, rst, tready, aclken,
		output tvalid, tdata, tlast, tuser
	);

	modport sink (
		input ref_clk, rst, tvalid, tdata, tlast, tuser, aclken,
		output tready
	);
endinterface : vsf_link_if

// ===== rtl/vsf_source.sv
/*
 * Pixel source end: packs user pixels into stream beats and adds frame and line markers.
 * Assumes the user side holds pix_valid and pix_comp until pix_ready, and the sink
 * is configured to the same format and resolution.
 */
`timescale 1ns/1ps
`include "vsf_regs.svh"

module vsf_source #(
	parameter int COMP_MAX = `VSF_MAX_COMPONENTS,
	parameter int DATA_WIDTH = 48
) (
	// Link
	vsf_link_if.source link,
	// Format
	input wire logic [2:0] cfg_ncomp,
	input wire logic [1:0] cfg_cwidth,
	input wire logic [`VSF_CNT_WIDTH-1:0] cfg_line_width,
	input wire logic [`VSF_CNT_WIDTH-1:0] cfg_line_count,
	// User pixels
	input wire logic pix_valid,
	input wire logic [COMP_MAX*16-1:0] pix_comp,
	output logic pix_ready,
	// Status
	output logic frame_done
);
	import vsf_pkg::*;

	// =============================================================
	// Pixel and line position
	// =============================================================
	vsf_count_t x_pos;
	vsf_count_t y_pos;
	vsf_count_t next_x_pos;
	vsf_count_t next_y_pos;
	logic next_frame_done;
	logic [DATA_WIDTH-1:0] packed_word;
	logic take;
	logic out_valid;
	logic next_out_valid;
	logic [DATA_WIDTH-1:0] out_data;
	logic [DATA_WIDTH-1:0] next_out_data;
	logic out_last;
	logic next_out_last;
	logic out_sof;
	logic next_out_sof;

	// Fixed order: component 0 in the low bits, zeros above the last one.
	always_comb begin
		logic [4:0] bits;
		bits = vsf_comp_bits(cfg_cwidth);
		packed_word = '0;
		for (int c = 0; c < COMP_MAX; c++) begin
			for (int b = 0; b < 16; b++) begin
				if (c < int'(cfg_ncomp) && b < int'(bits) && c * int'(bits) + b < DATA_WIDTH) begin
					packed_word[c * int'(bits) + b] = pix_comp[c * 16 + b];
				end
			end
		end
	end

	// The output register is free when aclken is high and it is empty or being taken.
	assign take = pix_valid && pix_ready;

	always_comb begin
		next_x_pos = x_pos;
		next_y_pos = y_pos;
		next_out_valid = out_valid;
		next_out_data = out_data;
		next_out_last = out_last;
		next_out_sof = out_sof;
		next_frame_done = 1'b0;
		if (link.aclken && out_valid && link.tready) begin
			next_out_valid = 1'b0;
		end
		if (take) begin
			// Only active pixels arrive from the user side, so no blanking beat exists.
			next_out_valid = 1'b1;
			next_out_data = packed_word;
			next_out_sof = (x_pos == '0) && (y_pos == '0);
			next_out_last = (x_pos == cfg_line_width - 1'b1);
			if (x_pos == cfg_line_width - 1'b1) begin
				next_x_pos = '0;
				if (y_pos == cfg_line_count - 1'b1) begin
					next_y_pos = '0;
					next_frame_done = 1'b1;
				end else begin
					next_y_pos = y_pos + 1'b1;
				end
			end else begin
				next_x_pos = x_pos + 1'b1;
			end
		end
	end

	always_ff @(posedge link.ref_clk or posedge link.rst) begin
		if (link.rst) begin
			x_pos <= '0;
			y_pos <= '0;
			out_valid <= 1'b0;
			out_data <= '0;
			out_last <= 1'b0;
			out_sof <= 1'b0;
			frame_done <= 1'b0;
		end else begin
			x_pos <= next_x_pos;
			y_pos <= next_y_pos;
			out_valid <= next_out_valid;
			out_data <= next_out_data;
			out_last <= next_out_last;
			out_sof <= next_out_sof;
			frame_done <= next_frame_done;
		end
	end

	// Marker bits ride in the same register as their pixel, so they stay aligned.
	assign link.tvalid = out_valid;
	assign link.tdata = out_data;
	assign link.tlast = out_last;
	assign link.tuser = `VSF_USER_WIDTH'(out_sof);
	assign pix_ready = link.aclken && (!out_valid || link.tready);

endmodule : vsf_source

// ===== tb/vsf_link_checker.sv
/* Checker for the stream link between source and sink: framing and hold rules.
 * Assumes one clock, aclken shared by both ends and a fixed line geometry. */
`timescale 1ns/1ps

module vsf_link_checker #(
	parameter int LINE_W = 4,
	parameter int LINE_N = 2,
	parameter int DATA_WIDTH = 48
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Link
	input wire logic tvalid,
	input wire logic tready,
	input wire logic [DATA_WIDTH-1:0] tdata,
	input wire logic tlast,
	input wire logic [0:0] tuser,
	input wire logic aclken
);
	// ==========
	// Position of the current beat in the frame
	// ==========
	int beat;
	int line;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			beat <= 0;
			line <= 0;
		end else if (tvalid && tready && aclken) begin
			beat <= tlast ? 0 : beat + 1;
			if (tlast) begin
				line <= (line == LINE_N - 1) ? 0 : line + 1;
			end
		end
	end

	// ==========
	// Properties
	// ==========
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_take;
		tvalid && tready && aclken;
	endsequence
	sequence s_wait;
		tvalid && !(tready && aclken);
	endsequence

	chk_eol_at_width: assert property (s_take ##0 beat == LINE_W - 1 |-> tlast)
		else $error("line end missing on last pixel");
	chk_eol_not_early: assert property (s_take ##0 tlast |-> beat == LINE_W - 1)
		else $error("line end on wrong pixel");
	chk_sof_first_only: assert property (s_take ##0 tuser[0] |-> beat == 0 && line == 0)
		else $error("frame start on wrong pixel");
	chk_sof_at_start: assert property (s_take ##0 beat == 0 && line == 0 |-> tuser[0])
		else $error("frame start missing");
	chk_valid_held: assert property (s_wait |=> tvalid)
		else $error("valid dropped before transfer");
	chk_beat_held: assert property (s_wait |=> $stable(tdata) && $stable(tlast) && $stable(tuser))
		else $error("beat changed before transfer");
	chk_quiet_after_reset: assert property ($fell(rst) |-> !tvalid)
		else $error("beat offered at reset release");
	chk_ready_after_reset: assert property ($fell(rst) |-> ##[0:2] tready)
		else $error("ready not raised after reset");
endmodule : vsf_link_checker

// ===== tb/tb.sv
/* Bench: source and sink joined by one link, a second sink fed broken beats.
 * Assumes the rtl package, interface and both ends are compiled first. */
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, (a), (b)); end end

module tb;
	import vsf_pkg::*;
	localparam int LW = 4;
	localparam int LN = 2;
	logic ref_clk = 0;
	logic rst = 1;
	logic [2:0] ncomp = 3;
	logic [1:0] cw = 0;
	logic s_valid = 0;
	logic [63:0] s_comp = 0;
	logic k_ready = 1;
	logic s_ready, done, k_valid, k_sof, k_eol, k_err, k_lock, b_valid, b_err;
	logic [63:0] k_comp;
	int n_fail = 0;
	int tests_run = 0;
	int n_done, n_berr, n_bv, n_kerr;
	int bw[4] = '{8, 10, 12, 16};
	logic [63:0] rx_q[$];
	logic [1:0] mk_q[$];
	logic [47:0] tx_q[$];

	// ==========
	// Both ends, the fault path and the checker
	// ==========
	vsf_link_if lnk (.ref_clk(ref_clk), .rst(rst));
	vsf_link_if lnk_b (.ref_clk(ref_clk), .rst(rst));
	vsf_source vsf_source_inst (.link(lnk.source), .cfg_ncomp(ncomp), .cfg_cwidth(cw),
		.cfg_line_width(vsf_count_t'(LW)), .cfg_line_count(vsf_count_t'(LN)),
		.pix_valid(s_valid), .pix_comp(s_comp), .pix_ready(s_ready), .frame_done(done));
	vsf_sink vsf_sink_inst (.link(lnk.sink), .cfg_ncomp(ncomp), .cfg_cwidth(cw),
		.cfg_line_width(vsf_count_t'(LW)), .cfg_line_count(vsf_count_t'(LN)),
		.pix_valid(k_valid), .pix_comp(k_comp), .pix_sof(k_sof), .pix_eol(k_eol),
		.pix_ready(k_ready), .frame_error(k_err), .locked(k_lock));
	vsf_sink vsf_sink_inst_b (.link(lnk_b.sink), .cfg_ncomp(ncomp), .cfg_cwidth(cw),
		.cfg_line_width(vsf_count_t'(LW)), .cfg_line_count(vsf_count_t'(LN)),
		.pix_valid(b_valid), .pix_comp(), .pix_sof(), .pix_eol(), .pix_ready(1'b1),
		.frame_error(b_err), .locked());
	vsf_link_checker #(.LINE_W(LW), .LINE_N(LN)) vsf_link_checker_inst (.ref_clk(ref_clk),
		.rst(rst), .tvalid(lnk.tvalid), .tready(lnk.tready), .tdata(lnk.tdata),
		.tlast(lnk.tlast), .tuser(lnk.tuser), .aclken(lnk.aclken));

	initial forever #12.5 ref_clk = ~ref_clk;

	// Sampling on the falling edge sees what the next rising edge will take.
	always @(negedge ref_clk) begin
		if (k_valid && k_ready) begin
			rx_q.push_back(k_comp);
			mk_q.push_back({k_sof, k_eol});
		end
		if (lnk.tvalid && lnk.tready && lnk.aclken) tx_q.push_back(lnk.tdata);
		n_done += done;
		n_kerr += k_err;
		n_berr += b_err;
		n_bv += b_valid;
	end

	// ==========
	// Shared tasks
	// ==========
	function automatic logic [15:0] pval(int i, int c, int b);
		pval = 16'((i * 16'h13a7 + c * 16'h05e1 + 16'h00c3) & ((1 << b) - 1));
	endfunction : pval

	task automatic wait_cyc(int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wait_cyc

	task automatic send_pix(int i, int nc, int b);
		logic [63:0] v;
		logic ok;
		v = 0;
		for (int c = 0; c < nc; c++) v[c * 16 +: 16] = pval(i, c, b);
		s_comp = v;
		ok = 0;
		for (int t = 0; t < 100 && !ok; t++) begin
			@(negedge ref_clk);
			ok = (s_ready === 1'b1) && (lnk.aclken === 1'b1);
			wait_cyc(1);
		end
		if (!ok) begin n_fail++; results(); end
	endtask : send_pix

	task automatic run_frame(int nc, int code, int hold_k, int hold_e);
		int b;
		int k;
		logic [47:0] w;
		b = bw[code];
		ncomp = 3'(nc);
		cw = 2'(code);
		rx_q.delete();
		mk_q.delete();
		tx_q.delete();
		n_done = 0;
		n_kerr = 0;
		s_valid = 1;
		fork
			begin wait_cyc(2); k_ready = 0; wait_cyc(hold_k); k_ready = 1; end
			begin wait_cyc(3); lnk.aclken = 0; wait_cyc(hold_e); lnk.aclken = 1; end
			begin
				for (int i = 0; i < LW * LN; i++) send_pix(i, nc, b);
				s_valid = 0;
			end
		join
		for (k = 0; k < 200 && rx_q.size() < LW * LN; k++) wait_cyc(1);
		if (k == 200) begin n_fail++; results(); end
		`CHK(n_done, 1)
		`CHK(tx_q.size(), LW * LN)
		`CHK(n_kerr, 0)
		`CHK(k_lock, 1'b0)
		for (int i = 0; i < LW * LN; i++) begin
			w = 0;
			for (int c = 0; c < nc; c++) w |= 48'(pval(i, c, b)) << (c * b);
			`CHK(tx_q[i], w)
			for (int c = 0; c < nc; c++) `CHK(rx_q[i][c * 16 +: 16], pval(i, c, b))
			`CHK(mk_q[i], {i == 0, i % LW == LW - 1})
		end
	endtask : run_frame

	task automatic put_beat(logic sof, logic eol);
		logic ok;
		lnk_b.tvalid = 1;
		lnk_b.tuser = sof;
		lnk_b.tlast = eol;
		lnk_b.tdata = 48'h0000_0000_1234;
		ok = 0;
		for (int t = 0; t < 100 && !ok; t++) begin
			@(negedge ref_clk);
			ok = (lnk_b.tready === 1'b1);
			wait_cyc(1);
		end
		if (!ok) begin n_fail++; results(); end
	endtask : put_beat

	// ==========
	// Scenarios
	// ==========
	task automatic t_formats();
		int nc[6] = '{4, 3, 4, 3, 1, 2};
		int cd[6] = '{0, 1, 2, 3, 0, 3};
		for (int j = 0; j < 6; j++) run_frame(nc[j], cd[j], 1, 1);
	endtask : t_formats

	// A long receiver stall fills the two-entry buffer while the source waits.
	task automatic t_stall();
		run_frame(3, 0, 12, 1);
	endtask : t_stall

	task automatic t_clken();
		run_frame(3, 2, 1, 6);
	endtask : t_clken

	// An early line end breaks the frame; the next frame start must relock.
	task automatic t_resync();
		n_berr = 0;
		put_beat(1, 0);
		put_beat(0, 1);
		lnk_b.tvalid = 0;
		lnk_b.tdata = ~lnk_b.tdata;
		wait_cyc(4);
		n_bv = 0;
		for (int i = 0; i < LW * LN; i++) put_beat(i == 0, i % LW == LW - 1);
		lnk_b.tvalid = 0;
		lnk_b.tdata = ~lnk_b.tdata;
		wait_cyc(6);
		`CHK(n_berr, 1)
		`CHK(n_bv, LW * LN)
	endtask : t_resync

	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : results

	initial begin
		lnk.aclken = 1;
		lnk_b.aclken = 1;
		lnk_b.tvalid = 0;
		lnk_b.tdata = 0;
		lnk_b.tlast = 0;
		lnk_b.tuser = 0;
		wait_cyc(3);
		rst = 0;
		t_formats();
		t_stall();
		t_clken();
		t_resync();
		results();
	end
endmodule : tb
